/* src/dplf_consts.svh */
`ifndef DPLF_CONSTS_SVH
`define DPLF_CONSTS_SVH

// Register map (byte addresses, word aligned)
`define DPLF_ADDR_CFG 4'h0
`define DPLF_ADDR_STATUS 4'h4
`define DPLF_ADDR_ERR 4'h8
// Config fields and reset value
`define DPLF_CFG_RESET 8'hA2
`define DPLF_BIT_EN 7
`define DPLF_BIT_NOACT 6
`define DPLF_BIT_NARROW 5
`define DPLF_LIM_HI 2
`define DPLF_LIM_LO 0
`define DPLF_CFG_USED_MASK 8'hE7
// Window base size in phase error units, doubled per code step
`define DPLF_WIN_BASE 16'h0010
// Lock settling time, 1 s at 100 MHz
`define DPLF_SETTLE_MS 1000
`define DPLF_CLK_KHZ 100000
`define DPLF_SETTLE_CYC (`DPLF_SETTLE_MS * `DPLF_CLK_KHZ)

`endif

/* src/dplf_pkg.sv */
package dplf_pkg;
  // Configuration register fields
  typedef struct packed {
    logic fine_en;
    logic inactive_ref_loss_select;
    logic narrow_test;
    logic [1:0] unused;
    logic [2:0] limit;
  } dplf_cfg_t;

  // Lock state machine
  typedef enum logic [1:0] {
    DPLF_LOST = 2'b01,
    DPLF_LOCKED = 2'b10
  } dplf_state_t;
endpackage

/* src/dplf_fine_detect.sv */
`timescale 1ns/1ps
`include "dplf_consts.svh"
module dplf_fine_detect #(
  parameter int unsigned SETTLE_CYC = `DPLF_SETTLE_CYC
) (
  input wire logic clk,
  input wire logic reset,
  // Avalon-MM slave
  input wire logic [3:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  // Phase detector and other loss sources
  input wire logic [15:0] phase_err,
  input wire logic ref_active,
  input wire logic other_loss,
  // Status
  output logic phase_lock,
  output logic phase_loss
);

  dplf_pkg::dplf_cfg_t cfg;
  dplf_pkg::dplf_state_t state;
  logic [1:0] ref_act_sync;
  logic [1:0] other_sync;
  logic [31:0] settle_cnt;
  logic [15:0] window;
  logic [15:0] err_abs;
  logic outside;
  logic inactive_loss;
  logic access_done;
  logic loss_now;

  // Synchronise pin level inputs
  always_ff @(posedge clk) begin
    if (reset) begin
      ref_act_sync <= 2'h0;
      other_sync <= 2'h0;
    end else begin
      ref_act_sync <= {ref_act_sync[0], ref_active};
      other_sync <= {other_sync[0], other_loss};
    end
  end

  // Window size doubles per code step
  always_comb begin
    window = 16'(`DPLF_WIN_BASE << cfg.limit);
  end

  // Magnitude of the signed phase error
  always_comb begin
    err_abs = phase_err[15] ? 16'(-phase_err) : phase_err;
  end

  // Window excursion counts only while the fine window is enabled
  always_comb begin
    outside = cfg.fine_en && (err_abs > window);
  end

  // Inactive reference counts only when selected
  always_comb begin
    inactive_loss = cfg.inactive_ref_loss_select && !ref_act_sync[1];
  end

  // Any loss source in this cycle
  always_comb begin
    loss_now = outside || other_sync[1] || inactive_loss;
  end

  // Bus handshake: one wait cycle, then answer
  always_ff @(posedge clk) begin
    if (reset) begin
      access_done <= 1'b0;
      waitrequest <= 1'b1;
    end else begin
      access_done <= (read || write) && waitrequest && !access_done;
      waitrequest <= !((read || write) && waitrequest && !access_done);
    end
  end

  // Configuration register
  always_ff @(posedge clk) begin
    if (reset) begin
      cfg <= `DPLF_CFG_RESET;
    end else if (write && !waitrequest && address == `DPLF_ADDR_CFG) begin
      cfg <= writedata[7:0] & `DPLF_CFG_USED_MASK;
    end
  end

  // Read data mux
  always_ff @(posedge clk) begin
    if (reset) begin
      readdata <= 32'h0;
    end else if (read && waitrequest && !access_done) begin
      case (address)
        `DPLF_ADDR_CFG: readdata <= {24'h0, cfg};
        `DPLF_ADDR_STATUS: readdata <= {28'h0, inactive_loss, outside, phase_loss, phase_lock};
        `DPLF_ADDR_ERR: readdata <= {16'h0, err_abs};
        default: readdata <= 32'h0;
      endcase
    end
  end

  // Lock settling and immediate loss
  always_ff @(posedge clk) begin
    if (reset) begin
      state <= dplf_pkg::DPLF_LOST;
      settle_cnt <= 32'h0;
    end else if (loss_now) begin
      state <= dplf_pkg::DPLF_LOST;
      settle_cnt <= 32'h0;
    end else begin
      case (state)
        dplf_pkg::DPLF_LOST: begin
          if (settle_cnt >= SETTLE_CYC - 1) begin
            state <= dplf_pkg::DPLF_LOCKED;
          end else begin
            settle_cnt <= settle_cnt + 32'h1;
          end
        end
        dplf_pkg::DPLF_LOCKED: settle_cnt <= 32'h0;
        default: state <= dplf_pkg::DPLF_LOST;
      endcase
    end
  end

  // Status outputs registered
  always_ff @(posedge clk) begin
    if (reset) begin
      phase_lock <= 1'b0;
      phase_loss <= 1'b1;
    end else begin
      phase_lock <= (state == dplf_pkg::DPLF_LOCKED) && !loss_now;
      phase_loss <= loss_now || (state != dplf_pkg::DPLF_LOCKED);
    end
  end

  // Loss and lock outputs
  chk_loss_immediate: assert property (@(posedge clk) disable iff (reset)
    outside
    |=> phase_loss)
    else $error("loss not raised after window excursion");

  chk_lock_needs_settle: assert property (@(posedge clk) disable iff (reset)
    $rose(phase_lock)
    |-> !$past(outside) && !$past(outside, 2))
    else $error("lock without settling");

  chk_disabled_window: assert property (@(posedge clk) disable iff (reset)
    (!cfg.fine_en && !other_sync[1] && !inactive_loss && state == dplf_pkg::DPLF_LOCKED)
    |=> !phase_loss)
    else $error("window loss while disabled");

  chk_inactive_select: assert property (@(posedge clk) disable iff (reset)
    (cfg.inactive_ref_loss_select && !ref_act_sync[1])
    |=> phase_loss)
    else $error("selected inactive reference did not raise loss");

  chk_lock_loss_excl: assert property (@(posedge clk) disable iff (reset)
    1'b1
    |-> !(phase_lock && phase_loss))
    else $error("lock and loss together");

  chk_loss_from_other: assert property (@(posedge clk) disable iff (reset)
    other_sync[1]
    |=> phase_loss)
    else $error("other loss source ignored");

  chk_lock_drop: assert property (@(posedge clk) disable iff (reset)
    loss_now
    |=> !phase_lock)
    else $error("lock held through a loss cycle");

  chk_lock_source: assert property (@(posedge clk) disable iff (reset)
    phase_lock
    |-> $past(state) == dplf_pkg::DPLF_LOCKED)
    else $error("lock shown outside locked state");

  chk_loss_source: assert property (@(posedge clk) disable iff (reset)
    phase_loss
    |-> $past(loss_now) || ($past(state) != dplf_pkg::DPLF_LOCKED))
    else $error("loss shown without a cause");

  chk_loss_after_reset: assert property (@(posedge clk)
    $fell(reset)
    |-> phase_loss && !phase_lock)
    else $error("status wrong after reset");

  // Settling counter and lock state
  chk_settle_count: assert property (@(posedge clk) disable iff (reset)
    (state == dplf_pkg::DPLF_LOST && !loss_now && settle_cnt < SETTLE_CYC - 1)
    |=> settle_cnt == $past(settle_cnt) + 32'h1)
    else $error("settling count did not advance");

  chk_settle_clear: assert property (@(posedge clk) disable iff (reset)
    loss_now
    |=> settle_cnt == 32'h0 && state == dplf_pkg::DPLF_LOST)
    else $error("settling not restarted after loss");

  chk_lock_entry: assert property (@(posedge clk) disable iff (reset)
    (state == dplf_pkg::DPLF_LOST && !loss_now && settle_cnt >= SETTLE_CYC - 1)
    |=> state == dplf_pkg::DPLF_LOCKED)
    else $error("lock not entered after settling");

  chk_lock_hold: assert property (@(posedge clk) disable iff (reset)
    (state == dplf_pkg::DPLF_LOCKED && !loss_now)
    |=> state == dplf_pkg::DPLF_LOCKED)
    else $error("lock left without a loss cause");

  chk_state_onehot: assert property (@(posedge clk) disable iff (reset)
    1'b1
    |-> $onehot(state))
    else $error("lock state not one-hot");

  chk_settle_bound: assert property (@(posedge clk) disable iff (reset)
    1'b1
    |-> settle_cnt < SETTLE_CYC)
    else $error("settling count overran");

  // Window configuration
  chk_window_scale: assert property (@(posedge clk) disable iff (reset)
    cfg.limit != 3'h0
    |-> window > (`DPLF_WIN_BASE << (cfg.limit - 3'h1)))
    else $error("window not growing with code");

  chk_reset_limit: assert property (@(posedge clk)
    $fell(reset)
    |-> cfg.limit == 3'h2)
    else $error("limit reset value wrong");

  // Bus handshake
  chk_wait_single: assert property (@(posedge clk) disable iff (reset)
    !waitrequest
    |=> waitrequest)
    else $error("waitrequest low for more than one cycle");

  chk_wait_answer: assert property (@(posedge clk) disable iff (reset)
    ((read || write) && waitrequest && !access_done)
    |=> !waitrequest)
    else $error("request not answered");

  chk_wait_idle: assert property (@(posedge clk) disable iff (reset)
    !(read || write)
    |=> waitrequest)
    else $error("answer without request");

  chk_wait_after_reset: assert property (@(posedge clk)
    $fell(reset)
    |-> waitrequest && (readdata == 32'h0))
    else $error("bus outputs wrong after reset");

  // Configuration register
  chk_cfg_write: assert property (@(posedge clk) disable iff (reset)
    (write && !waitrequest && address == `DPLF_ADDR_CFG)
    |=> cfg == (8'($past(writedata)) & `DPLF_CFG_USED_MASK))
    else $error("config write not applied");

  chk_cfg_unused: assert property (@(posedge clk) disable iff (reset)
    1'b1
    |-> (cfg & ~`DPLF_CFG_USED_MASK) == 8'h00)
    else $error("unused config bits set");

  chk_cfg_stable: assert property (@(posedge clk) disable iff (reset)
    !(write && !waitrequest && address == `DPLF_ADDR_CFG)
    |=> $stable(cfg))
    else $error("config changed without a write");

  // Read data
  chk_read_unmapped: assert property (@(posedge clk) disable iff (reset)
    (read && waitrequest && !access_done && address != `DPLF_ADDR_CFG && address != `DPLF_ADDR_STATUS && address != `DPLF_ADDR_ERR)
    |=> readdata == 32'h0)
    else $error("unmapped read not zero");

  chk_read_cfg: assert property (@(posedge clk) disable iff (reset)
    (read && waitrequest && !access_done && address == `DPLF_ADDR_CFG)
    |=> readdata == {24'h0, $past(cfg)})
    else $error("config read wrong");

  chk_read_status: assert property (@(posedge clk) disable iff (reset)
    (read && waitrequest && !access_done && address == `DPLF_ADDR_STATUS)
    |=> readdata[1:0] == {$past(phase_loss), $past(phase_lock)})
    else $error("status read wrong");

  // Synchronisers
  chk_sync_other: assert property (@(posedge clk) disable iff (reset)
    1'b1
    |-> other_sync[1] == $past(other_sync[0]))
    else $error("other loss synchroniser broken");

  chk_sync_ref: assert property (@(posedge clk) disable iff (reset)
    1'b1
    |-> ref_act_sync[1] == $past(ref_act_sync[0]))
    else $error("reference synchroniser broken");

endmodule

/* tb/dplf_fine_detect_tb.sv */
`timescale 1ns/1ps
module dplf_fine_detect_tb;
  // Bench drives
  logic clk = 0, reset = 1, read = 0, write = 0, ref_active = 1, other_loss = 0;
  logic [3:0] address = 4'h0;
  logic [31:0] writedata = 32'h0, rd, rs, readdata;
  logic [15:0] phase_err = 16'h0000;
  logic waitrequest, phase_lock, phase_loss;
  int failures = 0, checked = 0, n, w;
  dplf_fine_detect #(.SETTLE_CYC(20)) dut(.clk(clk), .reset(reset), .address(address), .read(read),
    .write(write), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .phase_err(phase_err), .ref_active(ref_active), .other_loss(other_loss),
    .phase_lock(phase_lock), .phase_loss(phase_loss));
  initial begin
    forever #5 clk = ~clk;
  end
  // Behavioural model: shadow config, two-stage synchronisers, count of clean cycles
  logic [7:0] m_cfg = 8'hA2;
  logic [1:0] m_oth = 2'h0, m_ref = 2'h0;
  logic [15:0] m_abs;
  logic m_lock = 1'b0, m_clean;
  int m_c = 0;
  always @(posedge clk) begin
    m_abs = phase_err[15] ? -phase_err : phase_err;
    m_clean = !(m_cfg[7] && m_abs > (16'h0010 << m_cfg[2:0])) && !m_oth[1] && !(m_cfg[6] && !m_ref[1]);
    if (reset) begin
      m_cfg <= 8'hA2;
      m_oth <= 2'h0;
      m_ref <= 2'h0;
      m_c <= 0;
      m_lock <= 1'b0;
    end else begin
      cmp_flag(phase_lock, m_lock);
      cmp_flag(phase_loss, !m_lock);
      m_c <= m_clean ? m_c + 1 : 0;
      m_lock <= m_clean && (m_c + 1 >= 21);
      m_oth <= {m_oth[0], other_loss};
      m_ref <= {m_ref[0], ref_active};
      if (write && !waitrequest && address == 4'h0) m_cfg <= writedata[7:0] & 8'hE7;
    end
  end
  // Verdict
  task automatic test_done;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic bad(input string m);
    failures++;
    $display("BAD %0t %s", $time, m);
  endtask
  task automatic cmp_reg(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) bad("register value");
  endtask
  task automatic cmp_flag(input logic g, input logic e);
    checked++;
    if (g !== e) bad("status flag");
  endtask
  // Avalon access, held until waitrequest sampled low
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    address <= a;
    writedata <= d;
    read <= !wr;
    write <= wr;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (waitrequest !== 1'b0 && n < 50);
    rd = readdata;
    read <= 1'b0;
    write <= 1'b0;
    if (n >= 50) begin
      bad("bus timeout");
      test_done();
    end
    @(posedge clk);
  endtask
  // Narrow test bit always kept at 1
  task automatic wcfg(input logic en, input logic sel, input logic [2:0] lim);
    bus(1'b1, 4'h0, {24'h0, en, sel, 1'b1, 2'b00, lim});
  endtask
  // Lock must not come before the settling count
  task automatic wait_lock;
    n = 0;
    while (phase_lock !== 1'b1 && n < 80) begin
      @(posedge clk);
      n++;
    end
    if (n >= 80) begin
      bad("lock timeout");
      test_done();
    end
    cmp_flag(phase_lock, 1'b1);
    cmp_flag(m_c >= 21, 1'b1);
    cmp_flag(phase_loss, 1'b0);
  endtask
  initial begin
    rs = $urandom(73177);
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    bus(1'b0, 4'h0, 32'h0);
    cmp_reg(rd, 32'h000000A2);
    bus(1'b0, 4'hC, 32'h0);
    cmp_reg(rd, 32'h0);
    rs = $urandom | 32'h20;
    bus(1'b1, 4'h0, rs);
    bus(1'b0, 4'h0, 32'h0);
    cmp_reg(rd, {24'h0, rs[7:0] & 8'hE7});
    $display("register test done");
    for (int lim = 0; lim < 8; lim++) begin
      wcfg(1'b1, 1'b0, lim[2:0]);
      w = 16 << lim;
      phase_err <= w[15:0];
      wait_lock();
      phase_err <= w[15:0] + 16'h0001;
      repeat (2) @(posedge clk);
      cmp_flag(phase_loss, 1'b1);
      cmp_flag(phase_lock, 1'b0);
      phase_err <= 16'h0000;
    end
    $display("window test done");
    wait_lock();
    wcfg(1'b0, 1'b0, 3'h0);
    phase_err <= 16'h7F00;
    repeat (4) @(posedge clk);
    cmp_flag(phase_loss, 1'b0);
    other_loss <= 1'b1;
    repeat (4) @(posedge clk);
    cmp_flag(phase_loss, 1'b1);
    bus(1'b0, 4'h4, 32'h0);
    cmp_reg(rd, 32'h00000002);
    bus(1'b0, 4'h8, 32'h0);
    cmp_reg(rd, 32'h00007F00);
    other_loss <= 1'b0;
    phase_err <= 16'h0000;
    $display("enable test done");
    wcfg(1'b1, 1'b1, 3'h2);
    wait_lock();
    ref_active <= 1'b0;
    repeat (4) @(posedge clk);
    cmp_flag(phase_loss, 1'b1);
    ref_active <= 1'b1;
    wcfg(1'b1, 1'b0, 3'h2);
    wait_lock();
    ref_active <= 1'b0;
    repeat (4) @(posedge clk);
    cmp_flag(phase_loss, 1'b0);
    $display("inactive reference test done");
    test_done();
  end
endmodule
